// ==== logic/pressure_sensor_i2c_readout.sv ====
// two-wire slave readout of a continuously refreshed pressure sample
//
// Behaviour
// - conversion loop ticks every 250 us; sample refreshed once per option period
// - slave only, answers when addressed
// - idle bus keeps both lines released
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - repeated requests without stop accepted
// - data changes only while scl low
// - eight-bit bytes, msb first
// - receiver acknowledges on ninth pulse
// - master nack ends device transmission
// - address byte: seven bits plus direction
// - answer on both configured addresses
// - read returns two bytes, 15-bit sample
// - fast option: 12 bit, 0.5 ms
// - high-res option: 1 ms update
// - code spans nominal 21845 counts
`include "sensor_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pressure_sensor_i2c_readout (
  input  wire  logic        ref_clk,
  input  wire  logic        rst_b,
  input  wire  logic        scl_i,
  input  wire  logic        sda_i,
  output logic              sda_o,
  output logic              sda_oe_b,
  output logic              scl_oe_b,
  input  wire  logic        hres_mode,
  input  wire  logic [14:0] raw_code,
  output logic [14:0] sample_r,
  output logic              sample_stb_r
);

  localparam int LOOP_N = `LOOP_CYCLES;
  localparam int FAST_N = `FAST_CYCLES;
  localparam int HRES_N = `HRES_CYCLES;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts when stages 2 and 3 agree

  logic [2:0] scl_sy_r;
  logic [2:0] sda_sy_r;
  sensor_pkg::bus_pins_t pin_r;
  sensor_pkg::bus_pins_t pin_prev_r;

  // shift in the raw pins
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], scl_i};
      sda_sy_r <= {sda_sy_r[1:0], sda_i};
    end
  end

  // filtered level only moves when the two late stages agree
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_r      <= '{scl: 1'b1, sda: 1'b1};
      pin_prev_r <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      pin_prev_r <= pin_r;
      if (scl_sy_r[1] == scl_sy_r[2]) pin_r.scl <= scl_sy_r[2];
      if (sda_sy_r[1] == sda_sy_r[2]) pin_r.sda <= sda_sy_r[2];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = pin_r.scl & ~pin_prev_r.scl;
  assign scl_fall  = ~pin_r.scl & pin_prev_r.scl;
  assign start_det = pin_r.scl & pin_prev_r.scl & pin_prev_r.sda & ~pin_r.sda;
  assign stop_det  = pin_r.scl & pin_prev_r.scl & ~pin_prev_r.sda & pin_r.sda;

  ////////////////////////////////////////////////////////////////////////
  // conversion loop: runs regardless of bus traffic

  logic [15:0] loop_cnt_r;
  logic [15:0] period;
  assign period = hres_mode ? 16'(HRES_N) : 16'(FAST_N);

  // a loop tick every LOOP_N cycles; the option period paces real updates
  logic [15:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == 16'(LOOP_N - 1));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) tick_cnt_r <= 16'h0000;
    else if (tick) tick_cnt_r <= 16'h0000;
    else tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) loop_cnt_r <= 16'h0000;
    else if (loop_cnt_r >= period - 16'h0001) loop_cnt_r <= 16'h0000;
    else loop_cnt_r <= loop_cnt_r + 16'h0001;
  end

  // clamp into the rated span and drop resolution, to 12 bits in fast mode and 13 in high-res
  function automatic logic [14:0] correct(input logic [14:0] raw, input logic hres);
    logic [14:0] v;
    v = raw;
    if (v > (`SAMPLE_RESET + `SPAN_NOMINAL)) v = `SAMPLE_RESET + `SPAN_NOMINAL;
    if (v < `SAMPLE_RESET) v = `SAMPLE_RESET;
    if (hres) v = {v[14:2], 2'h0};
    else v = {v[14:3], 3'h0};
    return v;
  endfunction

  // sample register written on each completed conversion period
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sample_r     <= `SAMPLE_RESET;
      sample_stb_r <= 1'b0;
    end else begin
      sample_stb_r <= 1'b0;
      if (loop_cnt_r >= period - 16'h0001) begin
        sample_r     <= correct(raw_code, hres_mode);
        sample_stb_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave state machine

  sensor_pkg::bus_state_t state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [15:0] tx_word_r;
  logic        byte_sel_r;
  logic        rd_r;
  logic        hold_low_r;

  function automatic logic addr_hit(input logic [6:0] a);
    return (a == `ADDR_PRIMARY) || (a == `ADDR_SECONDARY);
  endfunction

  // receive shifts on scl rise, drive updates on scl fall only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r    <= sensor_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_word_r  <= 16'h0000;
      byte_sel_r <= 1'b0;
      rd_r       <= 1'b0;
      hold_low_r <= 1'b0;
    end else if (start_det) begin
      state_r    <= sensor_pkg::ST_ADDR;
      bit_cnt_r  <= 4'h0;
      hold_low_r <= 1'b0;
    end else if (stop_det) begin
      state_r    <= sensor_pkg::ST_IDLE;
      hold_low_r <= 1'b0;
    end else begin
      unique case (state_r)
        sensor_pkg::ST_IDLE: begin
          hold_low_r <= 1'b0;
        end
        sensor_pkg::ST_ADDR, sensor_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], pin_r.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == sensor_pkg::ST_WDATA) begin
              hold_low_r <= 1'b1;
              state_r    <= sensor_pkg::ST_WACK;
            end else if (addr_hit(shift_r[7:1])) begin
              rd_r       <= shift_r[0];
              hold_low_r <= 1'b1;
              state_r    <= sensor_pkg::ST_ADDR_ACK;
              tx_word_r  <= {1'b0, sample_r};
            end else begin
              state_r <= sensor_pkg::ST_IDLE;
            end
          end
        end
        sensor_pkg::ST_ADDR_ACK, sensor_pkg::ST_WACK: begin
          if (scl_fall) begin
            if (rd_r && state_r == sensor_pkg::ST_ADDR_ACK) begin
              state_r    <= sensor_pkg::ST_TX;
              byte_sel_r <= 1'b0;
              hold_low_r <= ~tx_word_r[15];
              bit_cnt_r  <= 4'h1;
            end else begin
              state_r    <= sensor_pkg::ST_WDATA;
              hold_low_r <= 1'b0;
            end
          end
        end
        sensor_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
              hold_low_r <= 1'b0; // release for master ack
              state_r    <= sensor_pkg::ST_TX_ACK;
            end else begin
              hold_low_r <= ~tx_word_r[4'(15 - {byte_sel_r, 3'h0} - bit_cnt_r)];
              bit_cnt_r  <= bit_cnt_r + 4'h1;
            end
          end
        end
        sensor_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            rd_r <= ~pin_r.sda; // remember master ack
          end else if (scl_fall) begin
            if (!rd_r || byte_sel_r) begin
              state_r    <= sensor_pkg::ST_IDLE;
              hold_low_r <= 1'b0;
            end else begin
              byte_sel_r <= 1'b1;
              state_r    <= sensor_pkg::ST_TX;
              hold_low_r <= ~tx_word_r[7];
              bit_cnt_r  <= 4'h1;
            end
          end
        end
      endcase
    end
  end

  // open-drain outputs: output enable low means driving low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sda_oe_b <= 1'b1;
      sda_o    <= 1'b0;
      scl_oe_b <= 1'b1;
    end else begin
      sda_oe_b <= ~hold_low_r;
      sda_o    <= 1'b0;
      scl_oe_b <= 1'b1; // no clock stretching
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence addr_ack_seen;
    (state_r == sensor_pkg::ST_ADDR_ACK) && hold_low_r;
  endsequence

  chk_idle_released: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == sensor_pkg::ST_IDLE) && !start_det |=> ##1 sda_oe_b)
    else $error("sda driven while idle");
  chk_start_enters: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start_det |=> state_r == sensor_pkg::ST_ADDR)
    else $error("start not taken");
  chk_stop_idles: assert property (@(posedge ref_clk) disable iff (!rst_b)
    stop_det && !start_det |=> state_r == sensor_pkg::ST_IDLE)
    else $error("stop not taken");
  chk_sda_change_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(hold_low_r) && !$past(start_det) && !$past(stop_det) |-> !pin_r.scl)
    else $error("sda moved while scl high");
  chk_ack_address: assert property (@(posedge ref_clk) disable iff (!rst_b)
    addr_ack_seen |=> !sda_oe_b)
    else $error("address ack not driven");
  chk_sample_period: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sample_stb_r && !hres_mode |=> !sample_stb_r [*8])
    else $error("sample updated too soon");
  chk_msb_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    addr_ack_seen |-> !tx_word_r[15])
    else $error("top bit not zero");
  chk_nack_stops: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == sensor_pkg::ST_TX_ACK) && scl_fall && !rd_r && !start_det && !stop_det
    |=> state_r == sensor_pkg::ST_IDLE ##1 sda_oe_b)
    else $error("transmit after nack");
  chk_sample_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sample_r <= `SAMPLE_RESET + `SPAN_NOMINAL)
    else $error("sample beyond span");

  ////////////////////////////////////////////////////////////////////////
  // spacing monitor: counts cycles since the last sample strobe, so the
  // update period is checked with a counter instead of a long repetition
  // that the tools would have to unroll thousands of times

  logic [15:0] since_stb_r;
  logic        since_ok_r;
  logic        hres_prev_r;

  // a mode switch stretches or cuts one period, so it disarms the check
  // until the next strobe; the first strobe after reset only arms it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      since_stb_r <= 16'h0000;
      since_ok_r  <= 1'b0;
      hres_prev_r <= 1'b0;
    end else begin
      hres_prev_r <= hres_mode;
      if (sample_stb_r) begin
        since_stb_r <= 16'h0001;
        since_ok_r  <= 1'b1;
      end else if (since_stb_r != 16'hFFFF) begin
        since_stb_r <= since_stb_r + 16'h0001; // saturates, never wraps
      end
      if (hres_mode != hres_prev_r) since_ok_r <= 1'b0;
    end
  end

  // steady mode: strobes are exactly one option period apart
  chk_update_spacing: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sample_stb_r && since_ok_r && (hres_mode == hres_prev_r) |-> since_stb_r == period)
    else $error("sample update spacing wrong");

  // an address that is not ours leaves the line alone and drops to idle
  chk_foreign_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == sensor_pkg::ST_ADDR) && scl_fall && (bit_cnt_r == 4'h8) && !addr_hit(shift_r[7:1])
    && !start_det && !stop_det |=> (state_r == sensor_pkg::ST_IDLE) && !hold_low_r)
    else $error("foreign address answered");

  // address acknowledge is held until the master ends the ninth pulse
  chk_ack_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    addr_ack_seen && !scl_fall && !start_det && !stop_det |=> addr_ack_seen)
    else $error("address ack dropped early");

  // written data bytes are acknowledged even though they are discarded
  chk_write_ack: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == sensor_pkg::ST_WDATA) && scl_fall && (bit_cnt_r == 4'h8) && !start_det && !stop_det
    |=> (state_r == sensor_pkg::ST_WACK) ##1 !sda_oe_b)
    else $error("write data not acked");

  // after the eighth transmitted bit the line is freed for the master
  chk_tx_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state_r == sensor_pkg::ST_TX) && scl_fall && (bit_cnt_r == 4'h8) && !start_det && !stop_det
    |=> (state_r == sensor_pkg::ST_TX_ACK) && !hold_low_r ##1 sda_oe_b)
    else $error("line not freed for master ack");

endmodule // pressure_sensor_i2c_readout
`default_nettype wire

// ==== logic/sensor_map.svh ====
// register-free constants for the pressure sensor i2c readout
`ifndef SENSOR_MAP_SVH
`define SENSOR_MAP_SVH
`define ADDR_PRIMARY     7'h28
`define ADDR_SECONDARY   7'h29
`define CLK_RATE_HZ      10000000
`define LOOP_TIME_US     250
`define LOOP_CYCLES      ((`LOOP_TIME_US * `CLK_RATE_HZ) / 1000000)
`define FAST_UPDATE_US   500
`define FAST_CYCLES      ((`FAST_UPDATE_US * `CLK_RATE_HZ) / 1000000)
`define HRES_UPDATE_US   1000
`define HRES_CYCLES      ((`HRES_UPDATE_US * `CLK_RATE_HZ) / 1000000)
`define SPAN_NOMINAL     15'h5555
`define SPAN_MIN         15'h5333
`define SPAN_MAX         15'h5777
`define FAST_RES_BITS    12
`define HRES_RES_BITS    13
`define SAMPLE_RESET     15'h0AAB
`endif

// ==== logic/sensor_pkg.sv ====
// types shared by the pressure sensor readout
package sensor_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_TX,
    ST_TX_ACK
  } bus_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;
endpackage

// ==== bench/i2c_master_model.sv ====
// bus master model that drives the open-drain clock and data lines
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
  parameter int HALF = 10
) (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output var  logic scl_low,
  output var  logic sda_low
);
  ////////////////////////////////////////////////////////////////////////////
  // both lines released at time zero so the bus starts idle
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // works from idle or from a low clock, the latter being a repeated start
  task automatic start_cond();
    sda_low <= 1'b0;
    hold(HALF);
    scl_low <= 1'b0;
    hold(HALF);
    sda_low <= 1'b1;
    hold(HALF);
    scl_low <= 1'b1;
    hold(HALF);
  endtask

  // entered with the clock low after a byte
  task automatic stop_cond();
    sda_low <= 1'b1;
    hold(HALF);
    scl_low <= 1'b0;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask

  // data moves only in the low half; gap after the fall keeps the two
  // synchronisers from seeing clock and data change on one edge
  task automatic bit_cycle(input logic b, output logic r);
    sda_low <= ~b;
    hold(HALF);
    scl_low <= 1'b0;
    hold(HALF);
    r = sda_line;
    scl_low <= 1'b1;
    hold(HALF / 2);
  endtask

  // sending 8'hFF leaves the line to the device, so one task reads and writes
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic acked);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(tx[i], rx[i]);
    bit_cycle(ack_bit, r);
    acked = ~r;
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ==== bench/pressure_sensor_i2c_readout_tb_top.sv ====
// self-checking bench for the pressure sensor two-wire readout
`include "sensor_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pressure_sensor_i2c_readout_tb_top;
  logic        ref_clk;
  logic        rst_b;
  logic        hres_mode;
  logic [14:0] raw_code;
  logic        sda_o;
  logic        sda_oe_b;
  logic        scl_oe_b;
  logic [14:0] sample_r;
  logic        sample_stb_r;
  logic        scl_low;
  logic        sda_low;
  logic [14:0] want;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic        ak;
  int          bad_count;
  int          compares;
  // pull-ups win unless someone pulls low
  wire         scl_line = ~scl_low & scl_oe_b;
  wire         sda_line = ~sda_low & (sda_oe_b | sda_o);

  ////////////////////////////////////////////////////////////////////////////
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  pressure_sensor_i2c_readout dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_b(sda_oe_b), .scl_oe_b(scl_oe_b), .hres_mode(hres_mode), .raw_code(raw_code),
    .sample_r(sample_r), .sample_stb_r(sample_stb_r));
  i2c_master_model m (.ref_clk(ref_clk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] want_of(input logic [14:0] raw, input logic md);
    return raw & (md ? 15'h7FFC : 15'h7FF8);
  endfunction

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // bounded wait for the update strobe, returning cycles waited
  task automatic wait_stb(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (sample_stb_r !== 1'b1 && n < 20000);
  endtask

  // raw kept clear of the clamp limits so masking alone decides the value
  task automatic settle(input logic md);
    int n;
    logic [14:0] r;
    r = 15'h0B00 + 15'($urandom_range(0, 21504));
    want = want_of(r, md);
    @(posedge ref_clk);
    hres_mode <= md;
    raw_code <= r;
    wait_stb(n);
    wait_stb(n);
    chk(md || n == `FAST_CYCLES, "fast update spacing");
    chk(!md || n == `HRES_CYCLES, "high-res update spacing");
    chk(sample_r === want, "sample value");
  endtask

  task automatic read_pair(input logic [6:0] addr);
    m.byte_xfer({addr, 1'b1}, 1'b1, b1, ak);
    chk(ak === 1'b1, "read address ack");
    m.byte_xfer(8'hFF, 1'b0, b1, ak);
    m.byte_xfer(8'hFF, 1'b1, b2, ak);
    chk(b1 === {1'b0, want[14:8]}, "high byte");
    chk(b2 === want[7:0], "low byte");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well past the slowest pair of high-res updates plus bus work
  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(32'hCFC6CB08));
    rst_b = 1'b0;
    hres_mode = 1'b0;
    raw_code = 15'h0000;
    bad_count = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    #1 chk(sda_oe_b === 1'b1 && scl_oe_b === 1'b1 && sample_r === `SAMPLE_RESET, "reset state");
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int md = 0; md < 2; md++) begin
      settle(md[0]);
      m.start_cond();
      read_pair(`ADDR_PRIMARY);
      m.start_cond();
      read_pair(`ADDR_SECONDARY);
      m.stop_cond();
      repeat (20) @(posedge ref_clk);
      #1 chk(sda_line === 1'b1 && sda_oe_b === 1'b1, "idle bus released");
      $display("test read mode %0d done", md);
    end
    m.start_cond();
    m.byte_xfer({7'h2A, 1'b1}, 1'b1, b1, ak);
    chk(ak === 1'b0, "foreign address ignored");
    m.stop_cond();
    $display("test foreign address done");
    m.start_cond();
    m.byte_xfer({`ADDR_PRIMARY, 1'b0}, 1'b1, b1, ak);
    chk(ak === 1'b1, "write address ack");
    m.byte_xfer(8'($urandom), 1'b1, b1, ak);
    chk(ak === 1'b1, "write data ack");
    m.start_cond();
    read_pair(`ADDR_PRIMARY);
    m.stop_cond();
    $display("test write then read done");
    m.start_cond();
    m.byte_xfer({`ADDR_SECONDARY, 1'b1}, 1'b1, b1, ak);
    m.byte_xfer(8'hFF, 1'b1, b1, ak);
    repeat (12) @(posedge ref_clk);
    #1 chk(sda_oe_b === 1'b1, "released after master nack");
    m.stop_cond();
    $display("test nack done");
    complete_run();
  end
endmodule // pressure_sensor_i2c_readout_tb_top
`default_nettype wire
